// [hpc_pkg.sv]
package hpc_pkg;

  // ****************************************************************
  // Host port geometry.
  // ****************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int FIFO_LOW_W = 2;
  localparam logic [6:0] RX_WIN_BASE = 7'h00;
  localparam logic [6:0] TX_WIN_BASE = 7'h10;
  localparam logic [6:0] TX_WIN_LAST = 7'h1F;
  localparam logic [6:0] CSR_BASE = 7'h20;

  // ****************************************************************
  // Shared-pin role codes.
  // ****************************************************************
  localparam logic [1:0] ROLE_PROM = 2'h0;
  localparam logic [1:0] ROLE_GPO = 2'h1;
  localparam logic [1:0] ROLE_MON_EN = 2'h2;
  localparam logic [1:0] ROLE_MON_CLK = 2'h3;

  // ****************************************************************
  // Strap decode and reset values.
  // ****************************************************************
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic RESET_STRAP = 1'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

  typedef enum logic [2:0] {
    HPC_IDLE  = 3'b001,
    HPC_READ  = 3'b010,
    HPC_WRITE = 3'b100
  } hpc_state_t;

endpackage : hpc_pkg

// [hpc_sync.sv]
`timescale 1ns/100ps
// Three-stage synchroniser; the output changes once stages two and three
// agree, so a single-cycle glitch on a pin is never passed on.
module hpc_sync (
  // Clock and reset.
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  // Pin in, clean level out.
  input  wire logic PIN_IN,
  output logic      LEVEL_OUT
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic agree;

  assign agree = (s2_ff == s3_ff);

  // Shift the pin through three stages and update on agreement.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_ff     <= 1'b1;
      s2_ff     <= 1'b1;
      s3_ff     <= 1'b1;
      LEVEL_OUT <= 1'b1;
    end else begin
      s1_ff <= PIN_IN;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree) begin
        LEVEL_OUT <= s3_ff;
      end
    end
  end

endmodule : hpc_sync

// [hpc_host_port.sv]
`timescale 1ns/100ps
// Function
// - Decode halfword address bits seven to one into registers and FIFOs.
// - Read or write counts only when chip select accompanies the strobe.
// - A qualified host write ends the reduced power state.
// - One interrupt output with programmable polarity, sources and drive.
// - FIFO select high routes every access to a data FIFO.
// - FIFO select high ignores the five upper address bits.
// - Strap low: 10 Mbit half no autoneg; high: 100 half autoneg.
// - The strap is caught when reset is released and held.
// - Auto crossover on reversed cable, or manual reverse, swaps pairs.
// - Prom data pin: prom data, general output three, or TX monitor.
// - Data pin as output or TX monitor holds prom select off.
// - Prom clock pin: prom clock, general output four, or RX monitor.
// - Clock pin as output or RX monitor holds prom select off.
// - Shared pins in output role offer no input path.
module hpc_host_port
  import hpc_pkg::*;
(
  // Clock and reset.
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  // Host bus pins.
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic      [DATA_W-1:0] DATA_OUT,
  output logic                   DATA_OE,
  input  wire logic              SELECT_N,
  input  wire logic              READ_STROBE_N,
  input  wire logic              WRITE_STROBE_N,
  input  wire logic              FIFO_WINDOW_SEL,
  // Internal access port toward registers and FIFOs.
  output logic                   CSR_RD_PULSE,
  output logic                   CSR_WR_PULSE,
  output logic                   RX_FIFO_RD_PULSE,
  output logic                   TX_FIFO_WR_PULSE,
  output logic      [ADDR_W-1:0] ACC_ADDR,
  output logic      [DATA_W-1:0] ACC_WDATA,
  input  wire logic [DATA_W-1:0] ACC_RDATA,
  // Power state.
  input  wire logic              SLEEP_REQ,
  output logic                   SLEEPING,
  output logic                   WAKE_PULSE,
  // Interrupt request.
  input  wire logic [7:0]        IRQ_SOURCES,
  input  wire logic [7:0]        IRQ_ENABLE,
  input  wire logic              IRQ_ACTIVE_HIGH,
  input  wire logic              IRQ_PUSH_PULL,
  output logic                   IRQ_OUT,
  output logic                   IRQ_OE,
  // Rate strap and default link setup.
  input  wire logic              SPEED_STRAP,
  output logic      [1:0]        LINK_SPEED,
  output logic                   LINK_FULL_DUPLEX,
  output logic                   LINK_AUTONEG,
  // Crossover control.
  input  wire logic              CROSSOVER_AUTO_ENABLE,
  input  wire logic              CABLE_REVERSED,
  input  wire logic              CROSSOVER_MANUAL,
  output logic                   PAIRS_SWAPPED,
  // Shared prom pins.
  input  wire logic [1:0]        DATA_PIN_ROLE,
  input  wire logic [1:0]        CLOCK_PIN_ROLE,
  input  wire logic              GENERAL_OUTPUT_THREE,
  input  wire logic              GENERAL_OUTPUT_FOUR,
  input  wire logic              MII_TX_EN,
  input  wire logic              MII_TX_CLK,
  input  wire logic              MII_RX_DV,
  input  wire logic              MII_RX_CLK,
  input  wire logic              PROM_SEL_REQ,
  input  wire logic              PROM_CLK_REQ,
  input  wire logic              PROM_DOUT_REQ,
  input  wire logic              PROM_DOE_REQ,
  input  wire logic              PROM_DATA_PIN_IN,
  output logic                   PROM_DIN,
  output logic                   PROM_DATA_PIN_OUT,
  output logic                   PROM_DATA_PIN_OE,
  output logic                   PROM_CLOCK_PIN,
  output logic                   PROM_SELECT
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic sel_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic fifo_s;
  logic pdin_s;

  hpc_sync u_sync_sel (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
                       .PIN_IN(SELECT_N), .LEVEL_OUT(sel_n_s));
  hpc_sync u_sync_rd (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
                      .PIN_IN(READ_STROBE_N), .LEVEL_OUT(rd_n_s));
  hpc_sync u_sync_wr (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
                      .PIN_IN(WRITE_STROBE_N), .LEVEL_OUT(wr_n_s));
  hpc_sync u_sync_fifo (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
                        .PIN_IN(FIFO_WINDOW_SEL), .LEVEL_OUT(fifo_s));
  hpc_sync u_sync_pdin (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
                        .PIN_IN(PROM_DATA_PIN_IN), .LEVEL_OUT(pdin_s));

  // ****************************************************************
  // Access qualification and address decode.
  // ****************************************************************
  hpc_state_t  state_ff;
  hpc_state_t  nxt_state;
  logic        rd_req;
  logic        wr_req;
  logic [6:0]  eff_addr;
  logic        hit_fifo;
  logic        hit_csr;
  logic        hit_tx;

  // Strobes without select are dropped here.
  assign rd_req = !sel_n_s && !rd_n_s;
  assign wr_req = !sel_n_s && !wr_n_s && rd_n_s;
  // In window mode only the low two address bits survive.
  assign eff_addr = fifo_s ? {5'h00, ADDR[FIFO_LOW_W-1:0]}
                           : ADDR;
  assign hit_csr  = !fifo_s && (eff_addr >= CSR_BASE);
  assign hit_fifo = !hit_csr;
  // In window mode a write goes to TX data and a read to RX data.
  assign hit_tx = fifo_s ? wr_req
                         : (eff_addr >= TX_WIN_BASE &&
                            eff_addr <= TX_WIN_LAST);

  // One access per strobe assertion; wait for release to rearm.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HPC_IDLE: begin
        if (rd_req) begin
          nxt_state = HPC_READ;
        end else if (wr_req) begin
          nxt_state = HPC_WRITE;
        end
      end
      HPC_READ: begin
        if (!rd_req) begin
          nxt_state = HPC_IDLE;
        end
      end
      HPC_WRITE: begin
        if (!wr_req) begin
          nxt_state = HPC_IDLE;
        end
      end
      default: nxt_state = HPC_IDLE;
    endcase
  end

  logic start_rd;
  logic start_wr;
  assign start_rd = (state_ff == HPC_IDLE) && rd_req;
  assign start_wr = (state_ff == HPC_IDLE) && !rd_req && wr_req;

  // Access pulses and captured address and write data.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff         <= HPC_IDLE;
      CSR_RD_PULSE     <= 1'b0;
      CSR_WR_PULSE     <= 1'b0;
      RX_FIFO_RD_PULSE <= 1'b0;
      TX_FIFO_WR_PULSE <= 1'b0;
      ACC_ADDR         <= 7'h00;
      ACC_WDATA        <= DATA_RESET;
    end else begin
      state_ff         <= nxt_state;
      CSR_RD_PULSE     <= start_rd && hit_csr;
      CSR_WR_PULSE     <= start_wr && hit_csr;
      RX_FIFO_RD_PULSE <= start_rd && hit_fifo && !hit_tx;
      TX_FIFO_WR_PULSE <= start_wr && hit_fifo && hit_tx;
      if (start_rd || start_wr) begin
        ACC_ADDR  <= eff_addr;
        ACC_WDATA <= DATA_IN;
      end
    end
  end

  // ****************************************************************
  // Read data drive; the host must not expect data before the strobe
  // has crossed the synchroniser, four clocks.
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_OUT <= DATA_RESET;
      DATA_OE  <= 1'b0;
    end else begin
      DATA_OUT <= ACC_RDATA;
      DATA_OE  <= rd_req && (state_ff == HPC_READ);
    end
  end

  // ****************************************************************
  // Power state; only a qualified write wakes the device.
  // ****************************************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SLEEPING   <= 1'b0;
      WAKE_PULSE <= 1'b0;
    end else begin
      WAKE_PULSE <= SLEEPING && wr_req;
      if (SLEEPING && wr_req) begin
        SLEEPING <= 1'b0;
      end else if (SLEEP_REQ) begin
        SLEEPING <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt output with programmable polarity and drive type.
  // ****************************************************************
  logic irq_any;
  assign irq_any = |(IRQ_SOURCES & IRQ_ENABLE);

  // Open-drain drives only the active level, so it can share a line.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ_OUT <= 1'b0;
      IRQ_OE  <= 1'b0;
    end else begin
      IRQ_OUT <= IRQ_ACTIVE_HIGH ? irq_any : !irq_any;
      IRQ_OE  <= IRQ_PUSH_PULL || irq_any;
    end
  end

  // ****************************************************************
  // Rate strap, taken once on the first edge after reset release.
  // ****************************************************************
  logic strap_taken_ff;
  logic strap_ff;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_taken_ff <= 1'b0;
      strap_ff       <= RESET_STRAP;
    end else if (!strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      strap_ff       <= SPEED_STRAP;
    end
  end

  // Defaults follow the held strap; duplex is half in both cases.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINK_SPEED       <= SPEED_10;
      LINK_FULL_DUPLEX <= 1'b0;
      LINK_AUTONEG     <= 1'b0;
    end else begin
      LINK_SPEED       <= strap_ff ? SPEED_100 : SPEED_10;
      LINK_FULL_DUPLEX <= 1'b0;
      LINK_AUTONEG     <= strap_ff;
    end
  end

  // ****************************************************************
  // Crossover and shared prom pins.
  // ****************************************************************
  logic data_mux;
  logic clock_mux;
  logic data_is_prom;
  logic clock_is_prom;

  assign data_is_prom  = (DATA_PIN_ROLE == ROLE_PROM);
  assign clock_is_prom = (CLOCK_PIN_ROLE == ROLE_PROM);
  assign data_mux = (DATA_PIN_ROLE == ROLE_GPO)    ? GENERAL_OUTPUT_THREE :
                    (DATA_PIN_ROLE == ROLE_MON_EN) ? MII_TX_EN :
                    (DATA_PIN_ROLE == ROLE_MON_CLK) ? MII_TX_CLK :
                    PROM_DOUT_REQ;
  assign clock_mux = (CLOCK_PIN_ROLE == ROLE_GPO)    ? GENERAL_OUTPUT_FOUR :
                     (CLOCK_PIN_ROLE == ROLE_MON_EN) ? MII_RX_DV :
                     (CLOCK_PIN_ROLE == ROLE_MON_CLK) ? MII_RX_CLK :
                     PROM_CLK_REQ;

  // Monitored clocks pass one flop; a trade of latency for clean pins.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PAIRS_SWAPPED     <= 1'b0;
      PROM_DATA_PIN_OUT <= 1'b0;
      PROM_DATA_PIN_OE  <= 1'b0;
      PROM_CLOCK_PIN    <= 1'b0;
      PROM_SELECT       <= 1'b0;
      PROM_DIN          <= 1'b0;
    end else begin
      PAIRS_SWAPPED <= (CROSSOVER_AUTO_ENABLE && CABLE_REVERSED) ||
                       CROSSOVER_MANUAL;
      PROM_DATA_PIN_OUT <= data_mux;
      PROM_DATA_PIN_OE  <= !data_is_prom || PROM_DOE_REQ;
      PROM_CLOCK_PIN    <= clock_mux;
      PROM_SELECT <= PROM_SEL_REQ && data_is_prom &&
                     clock_is_prom;
      PROM_DIN <= data_is_prom && pdin_s;
    end
  end

endmodule : hpc_host_port

// [hpc_host_model.sv]
`timescale 1ns/100ps
// ****************************************************************
// Embedded host processor on the asynchronous SRAM-like bus.
// ****************************************************************
module hpc_host_model
  import hpc_pkg::*;
(
  // Clock.
  input  wire logic              SYS_CLK,
  // Host bus toward the device.
  output logic      [ADDR_W-1:0] ADDR,
  output logic      [DATA_W-1:0] DATA_IN,
  output logic                   SELECT_N,
  output logic                   READ_STROBE_N,
  output logic                   WRITE_STROBE_N,
  output logic                   FIFO_WINDOW_SEL,
  input  wire logic [DATA_W-1:0] DATA_OUT,
  input  wire logic              DATA_OE
);
  logic [DATA_W-1:0] rdata;

  // The bus idles with every strobe released.
  initial begin
    ADDR = 7'h00;
    DATA_IN = 16'hFFFF;
    SELECT_N = 1'h1;
    READ_STROBE_N = 1'h1;
    WRITE_STROBE_N = 1'h1;
    FIFO_WINDOW_SEL = 1'h0;
  end

  // One access; strobes drop together with select and are held until
  // the device drives (reads) or for a fixed span (writes have no ack).
  task automatic access(input logic rd, sel, win, input logic [6:0] a,
                        input logic [15:0] d);
    int n;
    // A read that never gets an answer must not pass on stale data.
    rdata = 16'h0000;
    @(posedge SYS_CLK);
    ADDR <= a;
    FIFO_WINDOW_SEL <= win;
    DATA_IN <= d;
    SELECT_N <= !sel;
    READ_STROBE_N <= !rd;
    WRITE_STROBE_N <= rd;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (n < 12 && !(rd && sel && DATA_OE === 1'h1));
    if (DATA_OE === 1'h1) rdata = DATA_OUT;
    SELECT_N <= 1'h1;
    READ_STROBE_N <= 1'h1;
    WRITE_STROBE_N <= 1'h1;
    DATA_IN <= ~d; // A released bus must not keep showing the old data.
    repeat (8) @(posedge SYS_CLK);
  endtask : access
endmodule : hpc_host_model

// [hpc_host_port_monitor.sv]
`timescale 1ns/100ps
// ****************************************************************
// Port checker for the host port block.
// ****************************************************************
module hpc_host_port_monitor
  import hpc_pkg::*;
(
  // Clock, reset and host pins.
  input wire logic SYS_CLK, RST_N, SELECT_N, READ_STROBE_N, FIFO_WINDOW_SEL,
  // Access side.
  input wire logic DATA_OE, CSR_RD_PULSE, CSR_WR_PULSE, RX_FIFO_RD_PULSE,
  input wire logic TX_FIFO_WR_PULSE, SLEEPING, WAKE_PULSE,
  input wire logic [ADDR_W-1:0] ACC_ADDR,
  // Interrupt, link and crossover.
  input wire logic [7:0] IRQ_SOURCES, IRQ_ENABLE,
  input wire logic IRQ_ACTIVE_HIGH, IRQ_OUT, LINK_FULL_DUPLEX, LINK_AUTONEG,
  input wire logic [1:0] LINK_SPEED, DATA_PIN_ROLE, CLOCK_PIN_ROLE,
  input wire logic CROSSOVER_AUTO_ENABLE, CABLE_REVERSED, CROSSOVER_MANUAL,
  // Shared prom pins.
  input wire logic PAIRS_SWAPPED, GENERAL_OUTPUT_THREE, PROM_DATA_PIN_OUT,
  input wire logic PROM_SELECT, PROM_DIN
);
  // Helper levels; stability is asked of them so pipeline depth is free.
  wire logic csr_pulse = CSR_RD_PULSE | CSR_WR_PULSE;
  wire logic any_pulse = csr_pulse | RX_FIFO_RD_PULSE | TX_FIFO_WR_PULSE;
  wire logic want_swap = (CROSSOVER_AUTO_ENABLE & CABLE_REVERSED)
                         | CROSSOVER_MANUAL;
  wire logic irq_lvl = (|(IRQ_SOURCES & IRQ_ENABLE)) ~^ IRQ_ACTIVE_HIGH;
  wire logic not_prom = (DATA_PIN_ROLE != ROLE_PROM)
                        | (CLOCK_PIN_ROLE != ROLE_PROM);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  // Properties; six-cycle windows cover the pin synchroniser and the
  // register behind it, since a pulse lags the synchronised level by one.
  property p_nosel; SELECT_N [*6] |-> !any_pulse; endproperty
  a_nosel: assert property (p_nosel)
    else $error("access pulse without select");
  property p_oe; (SELECT_N | READ_STROBE_N) [*6] |-> !DATA_OE; endproperty
  a_oe: assert property (p_oe)
    else $error("data bus driven outside a read");
  property p_win; FIFO_WINDOW_SEL [*6] ##0 any_pulse |-> !csr_pulse;
  endproperty
  a_win: assert property (p_win)
    else $error("register access while window selected");
  property p_csr; csr_pulse |-> ACC_ADDR >= CSR_BASE; endproperty
  a_csr: assert property (p_csr)
    else $error("register access decoded below register base");
  property p_wake; WAKE_PULSE || $fell(SLEEPING) |-> WAKE_PULSE && !SLEEPING
    && $past(SLEEPING) && (CSR_WR_PULSE || TX_FIFO_WR_PULSE); endproperty
  a_wake: assert property (p_wake)
    else $error("wake not tied to a host write");
  property p_link;
    !LINK_FULL_DUPLEX && LINK_AUTONEG == (LINK_SPEED == SPEED_100);
  endproperty
  a_link: assert property (p_link)
    else $error("link defaults inconsistent");
  property p_hold; RST_N [*4] |-> $stable(LINK_SPEED) && $stable(LINK_AUTONEG);
  endproperty
  a_hold: assert property (p_hold)
    else $error("link default moved after reset");
  property p_prom; $stable(not_prom) && not_prom |=> !PROM_SELECT; endproperty
  a_prom: assert property (p_prom)
    else $error("prom select active with pin reused");
  property p_gpo; DATA_PIN_ROLE == ROLE_GPO && $stable(DATA_PIN_ROLE) |=>
    PROM_DATA_PIN_OUT == $past(GENERAL_OUTPUT_THREE) && !PROM_DIN; endproperty
  a_gpo: assert property (p_gpo)
    else $error("data pin output role wrong");
  property p_swap;
    $stable(want_swap) [*2] |=> PAIRS_SWAPPED == $past(want_swap);
  endproperty
  a_swap: assert property (p_swap)
    else $error("pair swap wrong");
  property p_irq; $stable(irq_lvl) [*2] |=> IRQ_OUT == $past(irq_lvl);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level wrong");

  // Main scenarios.
  c_csr: cover property (CSR_RD_PULSE);
  c_wake: cover property (WAKE_PULSE);
  c_win: cover property (FIFO_WINDOW_SEL && TX_FIFO_WR_PULSE);
endmodule : hpc_host_port_monitor

bind hpc_host_port hpc_host_port_monitor mon (.*);

// [hpc_host_port_tb.sv]
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  error_cnt++; $display("unexpected %s exp %h seen %h", n, e, s); end end
// ****************************************************************
// Self-checking bench for the host port block.
// ****************************************************************
module hpc_host_port_tb;
  import hpc_pkg::*;
  typedef struct packed {
    logic rd; logic win; logic [6:0] a; logic [3:0] vec; logic [6:0] m;
  } hpc_row_t;
  logic SYS_CLK = 1'h0, RST_N = 1'h0, SLEEP_REQ = 1'h0, SPEED_STRAP = 1'h1;
  logic [ADDR_W-1:0] ADDR, ACC_ADDR;
  logic [DATA_W-1:0] DATA_IN, DATA_OUT, ACC_WDATA, ACC_RDATA = 16'hA5C3;
  logic SELECT_N, READ_STROBE_N, WRITE_STROBE_N, FIFO_WINDOW_SEL, DATA_OE;
  logic CSR_RD_PULSE, CSR_WR_PULSE, RX_FIFO_RD_PULSE, TX_FIFO_WR_PULSE;
  logic SLEEPING, WAKE_PULSE, IRQ_OUT, IRQ_OE, PAIRS_SWAPPED, woke;
  logic [7:0] IRQ_SOURCES = 8'h00, IRQ_ENABLE = 8'h0F;
  logic IRQ_ACTIVE_HIGH = 1'h0, IRQ_PUSH_PULL = 1'h0;
  logic LINK_FULL_DUPLEX, LINK_AUTONEG, CROSSOVER_AUTO_ENABLE = 1'h0;
  logic [1:0] LINK_SPEED, DATA_PIN_ROLE = 2'h0, CLOCK_PIN_ROLE = 2'h0;
  logic CABLE_REVERSED = 1'h0, CROSSOVER_MANUAL = 1'h0, MII_TX_EN = 1'h1;
  logic GENERAL_OUTPUT_THREE = 1'h0, GENERAL_OUTPUT_FOUR = 1'h1;
  logic MII_TX_CLK = 1'h0, MII_RX_DV = 1'h0, MII_RX_CLK = 1'h1;
  logic PROM_SEL_REQ = 1'h1, PROM_CLK_REQ = 1'h0, PROM_DOUT_REQ = 1'h1;
  logic PROM_DOE_REQ = 1'h1, PROM_DATA_PIN_IN = 1'h1, PROM_DIN, PROM_SELECT;
  logic PROM_DATA_PIN_OUT, PROM_DATA_PIN_OE, PROM_CLOCK_PIN;
  logic [3:0] seen;
  logic [6:0] seen_addr;
  int error_cnt = 0, total_checks = 0;
  // Ordinary accesses: pulse order is csr read, csr write, rx, tx.
  hpc_row_t rows [6] = '{
    '{1'h1, 1'h0, 7'h25, 4'h8, 7'h7F}, '{1'h0, 1'h0, 7'h30, 4'h4, 7'h7F},
    '{1'h1, 1'h0, 7'h03, 4'h2, 7'h7F}, '{1'h0, 1'h0, 7'h1F, 4'h1, 7'h7F},
    '{1'h1, 1'h1, 7'h7D, 4'h2, 7'h03}, '{1'h0, 1'h1, 7'h22, 4'h1, 7'h03}};

  hpc_host_port dut (.*);
  hpc_host_model host (.*);
  always #20 SYS_CLK = ~SYS_CLK;

  // Records the last access pulse so one-cycle outputs are never missed.
  always @(posedge SYS_CLK) begin
    if (CSR_RD_PULSE | CSR_WR_PULSE | RX_FIFO_RD_PULSE | TX_FIFO_WR_PULSE) begin
      seen <= {CSR_RD_PULSE, CSR_WR_PULSE, RX_FIFO_RD_PULSE, TX_FIFO_WR_PULSE};
      seen_addr <= ACC_ADDR;
    end
    if (WAKE_PULSE) woke <= 1'h1;
  end

  task automatic go(input logic rd, sel, win, input logic [6:0] a);
    @(negedge SYS_CLK) seen = 4'h0;
    host.access(rd, sel, win, a, 16'h5A0F);
    @(negedge SYS_CLK);
  endtask : go

  // The strap is flipped after release so a late sample would show.
  task automatic do_reset;
    @(posedge SYS_CLK) RST_N <= 1'h0;
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'h1;
    repeat (3) @(posedge SYS_CLK);
    SPEED_STRAP <= ~SPEED_STRAP;
    repeat (3) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask : do_reset

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // A hang counts as a mismatch and still ends in the verdict.
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    error_cnt++;
    summarize();
  end

  // Main sequence; the first access after reset is a read.
  initial begin
    do_reset();
    `CHK("speed", SPEED_100, LINK_SPEED)
    `CHK("autoneg", 1'h1, LINK_AUTONEG)
    `CHK("duplex", 1'h0, LINK_FULL_DUPLEX)
    foreach (rows[i]) begin
      go(rows[i].rd, 1'h1, rows[i].win, rows[i].a);
      `CHK("pulse", rows[i].vec, seen)
      `CHK("addr", rows[i].a & rows[i].m, seen_addr & rows[i].m)
      if (rows[i].rd) `CHK("rdata", ACC_RDATA, host.rdata)
      else `CHK("wdata", 16'h5A0F, ACC_WDATA)
    end
    @(posedge SYS_CLK) SLEEP_REQ <= 1'h1;
    @(posedge SYS_CLK) SLEEP_REQ <= 1'h0;
    for (int j = 0; j < 2; j++) begin
      go(j[0], 1'h0, 1'h0, 7'h30);
      `CHK("nosel", 4'h0, seen)
    end
    `CHK("asleep", 1'h1, SLEEPING)
    woke = 1'h0;
    go(1'h0, 1'h1, 1'h0, 7'h30);
    `CHK("woke", 1'h1, woke)
    `CHK("awake", 1'h0, SLEEPING)
    for (int k = 0; k < 8; k++) begin
      @(posedge SYS_CLK) {CROSSOVER_AUTO_ENABLE, CABLE_REVERSED,
                          CROSSOVER_MANUAL} <= k[2:0];
      repeat (3) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      `CHK("swap", (k[2] & k[1]) | k[0], PAIRS_SWAPPED)
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge SYS_CLK) DATA_PIN_ROLE <= r[1:0];
      CLOCK_PIN_ROLE <= r[1:0];
      repeat (3) @(posedge SYS_CLK);
      @(negedge SYS_CLK) `CHK("dpin", ~r[0], PROM_DATA_PIN_OUT)
      `CHK("doe", 1'h1, PROM_DATA_PIN_OE)
      `CHK("cpin", r[0], PROM_CLOCK_PIN)
      `CHK("psel", r == 0, PROM_SELECT)
      `CHK("din", r == 0, PROM_DIN)
    end
    for (int q = 0; q < 8; q++) begin
      @(posedge SYS_CLK) IRQ_SOURCES <= q[0] ? 8'h04 : 8'h40;
      IRQ_ACTIVE_HIGH <= q[1];
      IRQ_PUSH_PULL <= q[2];
      repeat (3) @(posedge SYS_CLK);
      @(negedge SYS_CLK) `CHK("irq", q[0] ~^ q[1], IRQ_OUT)
      `CHK("irq_oe", q[2] | q[0], IRQ_OE)
    end
    do_reset();
    `CHK("speed", SPEED_10, LINK_SPEED)
    `CHK("autoneg", 1'h0, LINK_AUTONEG)
    `CHK("idle_oe", 1'h0, DATA_OE)
    summarize();
  end
endmodule : hpc_host_port_tb
